// ==== rtl/drive_monitor_register_read.sv ====
`timescale 1ns/1ns
// What this block does
// RQ1: Read-only status word with run, direction, ready, fault.
// RQ2: Fault code register; zero means no fault.
// RQ3: Basic fault codes 01 to 16.
// RQ4: Overcurrent, voltage and stop codes 18 to 28.
// RQ5: Keypad, parameter, link and copy codes 29-42.
// RQ6: Motor overtemperature and current limit; reserved codes.
// RQ7: Link failure reports external abnormal when commanded.
// RQ8: Frequency and voltage readbacks in documented units.
// RQ9: Bus voltage and output current readbacks.
// RQ10: Output power in tenths of kilowatt.
// RQ11: Loop feedback and input in tenth percent.
// RQ12: Analog inputs, thousand counts full scale.
// RQ13: Fixed product identification word.
// RQ14: Heat-sink temperature, ten counts per degree.
// RQ15: Drive to motor rated current ratio.
// RQ16: Function 03 returns consecutive registers from start.
// RQ17: Quantity limit 37 RTU, 17 ASCII.
// RQ18: Reads must stay within one register group.
// RQ19: Master requests at least one register.
// RQ20: RTU request layout: station, function, start, quantity.
// RQ21: Terminal inputs and relay outputs in 2522.
// RQ22: Normal reply echoes header, byte count, data.
// RQ23: Error reply sets function bit 7, exception code.
// RQ24: RTU check is CRC-16, low byte first.
// RQ25: ASCII frame colon, hex digits, LRC, CR LF.
module drive_monitor_register_read
  import monitor_pkg::*;
#(
  parameter logic [15:0] PRODUCT_ID = 16'h0A5A // Arbitrary value
)
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // Verified request bytes from the frame layer
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic rx_last,
  output logic rx_ready,
  // Response characters to the frame layer
  output logic tx_valid,
  output logic [7:0] tx_data,
  output logic tx_last,
  input wire logic tx_ready,
  // Link configuration
  input wire logic ascii_mode,
  input wire logic [7:0] station_addr,
  input wire logic external_abnormal_cmd,
  // Drive state
  input wire logic run_state,
  input wire logic reverse_state,
  input wire logic drive_ready,
  input wire logic data_setting_error,
  input wire logic [7:0] drive_fault_code,
  input wire logic link_failure_fault,
  input wire logic [3:0] terminal_input,
  input wire logic [1:0] relay_output,
  // Scaled measurements
  input wire logic [15:0] freq_setpoint,
  input wire logic [15:0] out_freq,
  input wire logic [15:0] out_voltage,
  input wire logic [15:0] dc_bus,
  input wire logic [15:0] out_current,
  input wire logic [15:0] out_power,
  input wire logic [15:0] loop_feedback,
  input wire logic [15:0] loop_input,
  input wire logic [15:0] analog_volt,
  input wire logic [15:0] analog_curr,
  input wire logic [15:0] heatsink_temp,
  input wire logic [15:0] rated_ratio,
  // Code shown on the display
  output logic [7:0] display_fault_code
);

  // ==========
  // Declarations
  logic [15:0] status_ff, nxt_status, fault_ff, nxt_fault;
  logic [15:0] terminal_ff, nxt_terminal, crc_ff, crc_next;
  logic [15:0] start_addr, quantity, qty_limit, reg_addr, reg_data;
  logic [7:0] req_ff [0:5];
  logic [3:0] rx_cnt_ff, nibble;
  gen_state_e g_state_ff, nxt_g_state;
  logic [7:0] idx_ff, last_idx_ff, exc_ff, lrc_sum_ff, tx_data_ff;
  logic [7:0] reported_code, exc_code, word_offset, body_byte, lrc_byte;
  logic [7:0] ascii_src, hex_char, nxt_char;
  logic [16:0] end_addr;
  logic frame_done_ff, len_ok_ff, nib_ff, chk_ff, tx_valid_ff, tx_last_ff;
  logic rx_take, drive_code_reserved, addr_hit, is_read, is_known;
  logic respond, load, byte_done, nxt_last;

  // ==========
  // Monitor register contents
  // Reserved drive codes and codes from 48 up read as no fault
  assign drive_code_reserved = (drive_fault_code >= FAULT_LAST_CODE) ||
    (drive_fault_code inside {8'h05, 8'h11, 8'h16, 8'h24, 8'h25, 8'h2B,
    8'h2F}); // see RQ6
  // Link failure maps to external abnormal when commanded
  assign reported_code = link_failure_fault ?
    (external_abnormal_cmd ? FAULT_EXT_ABNORMAL : FAULT_LINK_FAILURE) :
    (drive_code_reserved ? FAULT_NONE : drive_fault_code); // see RQ7
  // Status, fault and terminal words
  always_comb
  begin
    nxt_status = 16'h0000;
    nxt_status[RUN_BIT] = run_state; // see RQ1
    nxt_status[REVERSE_BIT] = reverse_state;
    nxt_status[READY_BIT] = drive_ready;
    nxt_status[ABNORMAL_BIT] = (reported_code != FAULT_NONE);
    nxt_status[SETTING_ERR_BIT] = data_setting_error;
    nxt_fault = {8'h00, reported_code}; // see RQ2, RQ3, RQ4, RQ5, RQ6
    nxt_terminal = 16'h0000;
    nxt_terminal[TERMINAL_LSB +: 4] = terminal_input; // see RQ21
    nxt_terminal[RELAY_LSB +: 2] = relay_output;
  end

  // Snapshot of the drive state
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      status_ff <= 16'h0000;
      fault_ff <= 16'h0000;
      terminal_ff <= 16'h0000;
    end
    else
    begin
      status_ff <= nxt_status;
      fault_ff <= nxt_fault;
      terminal_ff <= nxt_terminal;
    end
  end

  assign display_fault_code = fault_ff[7:0]; // see RQ7

  // ==========
  // Request capture
  // No new byte while a reply is pending or until its last character is loaded into the output register
  assign rx_ready = (g_state_ff == G_IDLE) && !frame_done_ff;
  assign rx_take = rx_valid && rx_ready;

  // One holding byte per request byte, six in frame order
  generate
    for (genvar b = 0; b < 6; b++)
    begin : g_req
      always_ff @(posedge sys_clk)
      begin
        if (reset)
          req_ff[b] <= 8'h00;
        else if (rx_take && (rx_cnt_ff == 4'(b)))
          req_ff[b] <= rx_data; // see RQ20
      end
    end
  endgenerate

  // Byte counter and end-of-frame pulse
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      rx_cnt_ff <= 4'h0;
      frame_done_ff <= 1'b0;
      len_ok_ff <= 1'b0;
    end
    else
    begin
      frame_done_ff <= rx_take && rx_last;
      if (rx_take && rx_last)
      begin
        rx_cnt_ff <= 4'h0;
        len_ok_ff <= (rx_cnt_ff == REQ_LAST_INDEX);
      end
      else if (rx_take && (rx_cnt_ff != 4'hF))
        rx_cnt_ff <= rx_cnt_ff + 4'h1;
    end
  end

  // ==========
  // Request checks
  assign start_addr = {req_ff[2], req_ff[3]};
  assign quantity = {req_ff[4], req_ff[5]};
  assign end_addr = {1'b0, start_addr} + {1'b0, quantity} - 17'h00001;
  assign qty_limit = ascii_mode ? ASCII_QTY_LIMIT : RTU_QTY_LIMIT;
  assign addr_hit = (req_ff[0] == station_addr) &&
    (req_ff[0] != BROADCAST_ADDR);
  assign is_read = (req_ff[1] == FUNC_READ);
  assign is_known = is_read || (req_ff[1] == FUNC_WRITE_ONE) ||
    (req_ff[1] == FUNC_LOOP) || (req_ff[1] == FUNC_WRITE_MANY);
  // Exception priority: function, start, amount, group span
  assign exc_code = !is_read ? EXC_BAD_FUNC : // see RQ23
    ((start_addr < GROUP_FIRST_ADDR) || (start_addr > GROUP_LAST_ADDR)) ?
      EXC_BAD_ADDR :
    ((quantity == 16'h0000) || (quantity > qty_limit)) ?
      EXC_BAD_AMOUNT : // see RQ17, RQ19
    (end_addr > {1'b0, GROUP_LAST_ADDR}) ? EXC_BAD_ADDR : // see RQ18
    EXC_NONE;
  // Functions 06, 08 and 10 belong to other banks and are left alone; unknown ones get an exception
  assign respond = frame_done_ff && addr_hit &&
    ((is_read && len_ok_ff) || !is_known);

  // ==========
  // Response byte selection
  assign word_offset = (idx_ff - 8'h03) >> 1;
  assign reg_addr = start_addr + {8'h00, word_offset}; // see RQ16

  monitor_reg_select u_select (
    .reg_addr(reg_addr),
    .status_word(status_ff),
    .fault_word(fault_ff),
    .terminal_word(terminal_ff),
    .freq_setpoint(freq_setpoint), // see RQ8
    .out_freq(out_freq),
    .out_voltage(out_voltage),
    .dc_bus(dc_bus), // see RQ9
    .out_current(out_current),
    .out_power(out_power), // see RQ10
    .loop_feedback(loop_feedback), // see RQ11
    .loop_input(loop_input),
    .analog_volt(analog_volt), // see RQ12
    .analog_curr(analog_curr),
    .product_id(PRODUCT_ID), // see RQ13
    .heatsink_temp(heatsink_temp), // see RQ14
    .rated_ratio(rated_ratio), // see RQ15
    .reg_data(reg_data)
  );

  // Header echo, then count or exception, then data high first
  assign body_byte = (idx_ff == 8'h00) ? req_ff[0] :
    (idx_ff == 8'h01) ?
      ((exc_ff != EXC_NONE) ? (req_ff[1] | EXC_FLAG) : req_ff[1]) :
    (idx_ff == 8'h02) ?
      ((exc_ff != EXC_NONE) ? exc_ff : (req_ff[5] << 1)) : // see RQ22
    (idx_ff[0] ? reg_data[15:8] : reg_data[7:0]);

  // ==========
  // Frame checks
  crc16_byte_step u_crc (
    .crc_in(crc_ff),
    .data_in(body_byte),
    .crc_out(crc_next)
  );

  assign lrc_byte = 8'h00 - lrc_sum_ff; // see RQ25
  assign ascii_src = (g_state_ff == G_CHECK) ? lrc_byte : body_byte;
  assign nibble = nib_ff ? ascii_src[3:0] : ascii_src[7:4];
  assign hex_char = (nibble < 4'hA) ? (8'h30 + {4'h0, nibble}) :
    (8'h37 + {4'h0, nibble});

  // ==========
  // Response generator
  assign load = (g_state_ff != G_IDLE) && (!tx_valid_ff || tx_ready);
  assign byte_done = !ascii_mode || nib_ff;

  // Next character and next state
  always_comb
  begin
    nxt_g_state = g_state_ff;
    nxt_char = 8'h00;
    nxt_last = 1'b0;
    case (g_state_ff)
      G_IDLE:
        if (respond)
          nxt_g_state = ascii_mode ? G_COLON : G_BODY;
      G_COLON:
      begin
        nxt_char = CHAR_COLON; // see RQ25
        nxt_g_state = G_BODY;
      end
      G_BODY:
      begin
        nxt_char = ascii_mode ? hex_char : body_byte;
        if (byte_done && (idx_ff == last_idx_ff))
          nxt_g_state = G_CHECK;
      end
      G_CHECK:
      begin
        if (ascii_mode)
        begin
          nxt_char = hex_char;
          if (nib_ff)
            nxt_g_state = G_CR;
        end
        else
        begin
          nxt_char = chk_ff ? crc_ff[15:8] : crc_ff[7:0]; // see RQ24
          nxt_last = chk_ff;
          if (chk_ff)
            nxt_g_state = G_IDLE;
        end
      end
      G_CR:
      begin
        nxt_char = CHAR_CR;
        nxt_g_state = G_LF;
      end
      G_LF:
      begin
        nxt_char = CHAR_LF;
        nxt_last = 1'b1;
        nxt_g_state = G_IDLE;
      end
      default: nxt_g_state = G_IDLE;
    endcase
  end

  // State, indices and running checks
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      g_state_ff <= G_IDLE;
      idx_ff <= 8'h00;
      last_idx_ff <= 8'h00;
      exc_ff <= EXC_NONE;
      nib_ff <= 1'b0;
      chk_ff <= 1'b0;
      crc_ff <= CRC_PRESET;
      lrc_sum_ff <= 8'h00;
    end
    else if (g_state_ff == G_IDLE)
    begin
      g_state_ff <= nxt_g_state;
      idx_ff <= 8'h00;
      nib_ff <= 1'b0;
      chk_ff <= 1'b0;
      crc_ff <= CRC_PRESET; // see RQ24
      lrc_sum_ff <= 8'h00;
      if (respond)
      begin
        exc_ff <= exc_code;
        last_idx_ff <= (exc_code != EXC_NONE) ? HEADER_LAST_INDEX :
          (HEADER_LAST_INDEX + (req_ff[5] << 1)); // see RQ22
      end
    end
    else if (load)
    begin
      g_state_ff <= nxt_g_state;
      if (g_state_ff == G_BODY)
      begin
        nib_ff <= ascii_mode && !nib_ff;
        if (byte_done)
        begin
          idx_ff <= idx_ff + 8'h01;
          crc_ff <= crc_next;
          lrc_sum_ff <= lrc_sum_ff + body_byte;
        end
      end
      else if (g_state_ff == G_CHECK)
      begin
        nib_ff <= !nib_ff;
        chk_ff <= !chk_ff;
      end
    end
  end

  // ==========
  // Output register toward the frame layer
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      tx_valid_ff <= 1'b0;
      tx_data_ff <= 8'h00;
      tx_last_ff <= 1'b0;
    end
    else if (load)
    begin
      tx_valid_ff <= 1'b1;
      tx_data_ff <= nxt_char;
      tx_last_ff <= nxt_last;
    end
    else if (tx_ready)
    begin
      tx_valid_ff <= 1'b0;
      tx_last_ff <= 1'b0;
    end
  end

  assign tx_valid = tx_valid_ff;
  assign tx_data = tx_data_ff;
  assign tx_last = tx_last_ff;

endmodule : drive_monitor_register_read

// ==== rtl/monitor_pkg.sv ====
package monitor_pkg;

  // ==========
  // Register map of the monitor group
  // ==========
  localparam logic [15:0] STATUS_WORD_ADDR = 16'h2520;
  localparam logic [15:0] FAULT_CODE_ADDR = 16'h2521;
  localparam logic [15:0] TERMINAL_IO_ADDR = 16'h2522;
  localparam logic [15:0] FREQ_SETPOINT_ADDR = 16'h2523;
  localparam logic [15:0] OUT_FREQ_ADDR = 16'h2524;
  localparam logic [15:0] OUT_VOLTAGE_ADDR = 16'h2525;
  localparam logic [15:0] DC_BUS_ADDR = 16'h2526;
  localparam logic [15:0] OUT_CURRENT_ADDR = 16'h2527;
  localparam logic [15:0] OUT_POWER_ADDR = 16'h2529;
  localparam logic [15:0] LOOP_FEEDBACK_ADDR = 16'h252A;
  localparam logic [15:0] LOOP_INPUT_ADDR = 16'h252B;
  localparam logic [15:0] ANALOG_VOLT_ADDR = 16'h252C;
  localparam logic [15:0] ANALOG_CURR_ADDR = 16'h252D;
  localparam logic [15:0] PRODUCT_ID_ADDR = 16'h252F;
  localparam logic [15:0] HEATSINK_TEMP_ADDR = 16'h2531;
  localparam logic [15:0] RATED_RATIO_ADDR = 16'h2532;
  localparam logic [15:0] GROUP_FIRST_ADDR = 16'h2520;
  localparam logic [15:0] GROUP_LAST_ADDR = 16'h2532;

  // ==========
  // Field positions
  // ==========
  localparam int RUN_BIT = 0;
  localparam int REVERSE_BIT = 1;
  localparam int READY_BIT = 2;
  localparam int ABNORMAL_BIT = 3;
  localparam int SETTING_ERR_BIT = 4;
  localparam int TERMINAL_LSB = 0;
  localparam int RELAY_LSB = 6;

  // ==========
  // Fault codes (numeric value of the decimal code)
  // ==========
  localparam logic [7:0] FAULT_NONE = 8'h00;
  localparam logic [7:0] FAULT_EXT_ABNORMAL = 8'h0E;
  localparam logic [7:0] FAULT_LINK_FAILURE = 8'h21;
  localparam logic [7:0] FAULT_LAST_CODE = 8'h30;

  // ==========
  // Protocol constants
  // ==========
  localparam logic [7:0] FUNC_READ = 8'h03;
  localparam logic [7:0] FUNC_WRITE_ONE = 8'h06;
  localparam logic [7:0] FUNC_LOOP = 8'h08;
  localparam logic [7:0] FUNC_WRITE_MANY = 8'h10;
  localparam logic [7:0] EXC_FLAG = 8'h80;
  localparam logic [7:0] EXC_BAD_FUNC = 8'h51;
  localparam logic [7:0] EXC_BAD_ADDR = 8'h52;
  localparam logic [7:0] EXC_BAD_AMOUNT = 8'h53;
  localparam logic [7:0] EXC_NONE = 8'h00;
  localparam logic [7:0] BROADCAST_ADDR = 8'h00;
  localparam logic [15:0] RTU_QTY_LIMIT = 16'h0025;
  localparam logic [15:0] ASCII_QTY_LIMIT = 16'h0011;
  localparam logic [15:0] CRC_PRESET = 16'hFFFF;
  localparam logic [15:0] CRC_POLY = 16'hA001;
  localparam logic [7:0] CHAR_COLON = 8'h3A;
  localparam logic [7:0] CHAR_CR = 8'h0D;
  localparam logic [7:0] CHAR_LF = 8'h0A;
  localparam logic [3:0] REQ_LAST_INDEX = 4'h5;
  localparam logic [7:0] HEADER_LAST_INDEX = 8'h02;

  // Response generator states
  typedef enum logic [2:0] {
    G_IDLE = 3'b000,
    G_COLON = 3'b001,
    G_BODY = 3'b010,
    G_CHECK = 3'b011,
    G_CR = 3'b100,
    G_LF = 3'b101
  } gen_state_e;

endpackage : monitor_pkg

// ==== rtl/crc16_byte_step.sv ====
`timescale 1ns/1ns
module crc16_byte_step
  import monitor_pkg::*;
(
  // Running value and next byte
  input wire logic [15:0] crc_in,
  input wire logic [7:0] data_in,
  // Value after the byte
  output logic [15:0] crc_out
);

  // ==========================================================
  // Eight reflected shifts with conditional polynomial
  // ==========================================================
  always_comb
  begin
    crc_out = crc_in ^ {8'h00, data_in};
    for (int i = 0; i < 8; i++)
    begin
      if (crc_out[0])
        crc_out = (crc_out >> 1) ^ CRC_POLY;
      else
        crc_out = crc_out >> 1;
    end
  end

endmodule : crc16_byte_step

// ==== rtl/monitor_reg_select.sv ====
`timescale 1ns/1ns
module monitor_reg_select
  import monitor_pkg::*;
(
  // Register address
  input wire logic [15:0] reg_addr,
  // Register contents
  input wire logic [15:0] status_word,
  input wire logic [15:0] fault_word,
  input wire logic [15:0] terminal_word,
  input wire logic [15:0] freq_setpoint,
  input wire logic [15:0] out_freq,
  input wire logic [15:0] out_voltage,
  input wire logic [15:0] dc_bus,
  input wire logic [15:0] out_current,
  input wire logic [15:0] out_power,
  input wire logic [15:0] loop_feedback,
  input wire logic [15:0] loop_input,
  input wire logic [15:0] analog_volt,
  input wire logic [15:0] analog_curr,
  input wire logic [15:0] product_id,
  input wire logic [15:0] heatsink_temp,
  input wire logic [15:0] rated_ratio,
  // Selected word
  output logic [15:0] reg_data
);

  // ==========================================================
  // Read decode; reserved slots read as zero
  // ==========================================================
  always_comb
  begin
    case (reg_addr)
      STATUS_WORD_ADDR: reg_data = status_word;
      FAULT_CODE_ADDR: reg_data = fault_word;
      TERMINAL_IO_ADDR: reg_data = terminal_word;
      FREQ_SETPOINT_ADDR: reg_data = freq_setpoint;
      OUT_FREQ_ADDR: reg_data = out_freq;
      OUT_VOLTAGE_ADDR: reg_data = out_voltage;
      DC_BUS_ADDR: reg_data = dc_bus;
      OUT_CURRENT_ADDR: reg_data = out_current;
      OUT_POWER_ADDR: reg_data = out_power;
      LOOP_FEEDBACK_ADDR: reg_data = loop_feedback;
      LOOP_INPUT_ADDR: reg_data = loop_input;
      ANALOG_VOLT_ADDR: reg_data = analog_volt;
      ANALOG_CURR_ADDR: reg_data = analog_curr;
      PRODUCT_ID_ADDR: reg_data = product_id;
      HEATSINK_TEMP_ADDR: reg_data = heatsink_temp;
      RATED_RATIO_ADDR: reg_data = rated_ratio;
      default: reg_data = 16'h0000;
    endcase
  end

endmodule : monitor_reg_select

// ==== testbench/drive_monitor_register_read_asserts.sv ====
`timescale 1ns/1ns
// ==========================================================
// Port checks of the monitor read block
module drive_monitor_register_read_asserts
  import monitor_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // Request and reply handshakes
  input wire logic rx_valid,
  input wire logic rx_last,
  input wire logic rx_ready,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_last,
  input wire logic tx_ready,
  // Link and fault state
  input wire logic ascii_mode,
  input wire logic [7:0] station_addr,
  input wire logic external_abnormal_cmd,
  input wire logic link_failure_fault,
  input wire logic [7:0] drive_fault_code,
  input wire logic [7:0] display_fault_code
);
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (reset);

  hold_tx_a: assert property (tx_valid && !tx_ready |=>
    tx_valid && $stable(tx_data) && $stable(tx_last))
    else $error("held reply character changed");
  frame_busy_a: assert property (rx_valid && rx_ready && rx_last
    |=> !rx_ready) else $error("request taken while frame pending");
  reply_end_a: assert property (tx_valid && tx_ready && tx_last
    |=> !tx_valid) else $error("reply runs past its last character");
  ascii_start_a: assert property ($rose(tx_valid) && ascii_mode
    |-> tx_data == CHAR_COLON) else $error("text reply lacks colon");
  rtu_station_a: assert property ($rose(tx_valid) && !ascii_mode
    |-> tx_data == station_addr) else $error("reply lacks station");
  ext_fault_a: assert property (link_failure_fault &&
    external_abnormal_cmd |=> display_fault_code == FAULT_EXT_ABNORMAL)
    else $error("external abnormal code not shown");
  link_fault_a: assert property (link_failure_fault &&
    !external_abnormal_cmd |=> display_fault_code == FAULT_LINK_FAILURE)
    else $error("link failure code not shown");
  no_fault_a: assert property (!link_failure_fault &&
    drive_fault_code == FAULT_NONE |=> display_fault_code == FAULT_NONE)
    else $error("idle drive shows a fault");
  code_pass_a: assert property (!link_failure_fault &&
    drive_fault_code inside {[8'h01:8'h04], [8'h06:8'h10]}
    |=> display_fault_code == $past(drive_fault_code))
    else $error("basic fault code not passed");
endmodule : drive_monitor_register_read_asserts

bind drive_monitor_register_read drive_monitor_register_read_asserts
  u_asserts (.sys_clk, .reset, .rx_valid, .rx_last, .rx_ready,
  .tx_valid, .tx_data, .tx_last, .tx_ready, .ascii_mode, .station_addr,
  .external_abnormal_cmd, .link_failure_fault, .drive_fault_code,
  .display_fault_code);

// ==== testbench/modbus_master_model.sv ====
`timescale 1ns/1ns
// ==========================================================
// Serial master stand-in: request bytes out, reply characters in
module modbus_master_model
(
  // Clock
  input wire logic sys_clk,
  // Request side
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic rx_last,
  input wire logic rx_ready,
  // Reply side
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_last,
  output logic tx_ready
);
  logic hung = 1'h0;

  // Quiet lines at time zero
  initial
  begin
    rx_valid = 1'h0;
    rx_data = 8'hA5;
    rx_last = 1'h0;
    tx_ready = 1'h0;
  end

  // Six bytes in fixed order, each held until taken or 60 cycles pass
  task automatic send(input logic [7:0] b[6]);
    int n;
    bit ok;
    for (int i = 0; i < 6; i++)
    begin
      rx_valid = 1'h1;
      rx_data = b[i];
      rx_last = (i == 5);
      n = 0;
      do
      begin
        ok = rx_ready; // Settled value, taken at the coming edge
        @(posedge sys_clk);
        #1;
        n++;
      end while (!ok && n < 60);
      hung |= !ok;
    end
    rx_valid = 1'h0;
    rx_last = 1'h0;
    rx_data = ~rx_data; // Released line shows no stale byte
  endtask : send

  // Take reply characters; slow mode stalls every other cycle
  task automatic collect(output logic [7:0] r[$], input bit slow);
    bit done;
    r = {};
    done = 1'h0;
    tx_ready = 1'h1;
    for (int n = 0; n < 200 && !done; n++)
    begin
      if (tx_valid && tx_ready)
      begin
        r.push_back(tx_data);
        done = tx_last;
      end
      @(posedge sys_clk);
      #1 tx_ready = !done && (!slow || !tx_ready);
    end
  endtask : collect
endmodule : modbus_master_model

// ==== testbench/drive_monitor_register_read_tb_top.sv ====
`timescale 1ns/1ns
// ==========================================================
// Self-checking bench of the monitor read block
module drive_monitor_register_read_tb_top
  import monitor_pkg::*;
;
  localparam logic [15:0] ID_VALUE = 16'h3C3C; // Arbitrary value
  logic sys_clk = 1'h0, reset = 1'h1, ascii_mode = 1'h0;
  logic external_abnormal_cmd = 1'h0, link_failure_fault = 1'h0;
  logic run_state = 1'h1, reverse_state = 1'h0, drive_ready = 1'h1;
  logic data_setting_error = 1'h1;
  logic [7:0] drive_fault_code = 8'h00, station_addr = 8'h07;
  logic [3:0] terminal_input = 4'hA;
  logic [1:0] relay_output = 2'h2;
  logic [15:0] meas [12];
  logic rx_valid, rx_last, rx_ready, tx_valid, tx_last, tx_ready;
  logic [7:0] rx_data, tx_data, display_fault_code;
  int num_errors = 0, compares = 0;

  always #50 sys_clk = ~sys_clk;

  // Design and master model
  drive_monitor_register_read #(.PRODUCT_ID(ID_VALUE)) u_dut (.sys_clk,
    .reset, .rx_valid, .rx_data, .rx_last, .rx_ready, .tx_valid, .tx_data,
    .tx_last, .tx_ready, .ascii_mode, .station_addr, .external_abnormal_cmd,
    .run_state, .reverse_state, .drive_ready, .data_setting_error,
    .drive_fault_code, .link_failure_fault, .terminal_input, .relay_output,
    .freq_setpoint(meas[0]), .out_freq(meas[1]), .out_voltage(meas[2]),
    .dc_bus(meas[3]), .out_current(meas[4]), .out_power(meas[5]),
    .loop_feedback(meas[6]), .loop_input(meas[7]), .analog_volt(meas[8]),
    .analog_curr(meas[9]), .heatsink_temp(meas[10]),
    .rated_ratio(meas[11]), .display_fault_code);
  modbus_master_model u_master (.sys_clk, .rx_valid, .rx_data, .rx_last,
    .rx_ready, .tx_valid, .tx_data, .tx_last, .tx_ready);

  // ==========================================================
  // Expected values
  function automatic logic [15:0] fault_exp();
    if (link_failure_fault)
      return external_abnormal_cmd ? 16'h000E : 16'h0021;
    if (drive_fault_code >= 8'h30 || drive_fault_code inside
        {8'h05, 8'h11, 8'h16, 8'h24, 8'h25, 8'h2B, 8'h2F})
      return 16'h0000;
    return {8'h00, drive_fault_code};
  endfunction : fault_exp

  function automatic logic [15:0] reg_exp(input logic [15:0] a);
    case (a)
      16'h2520: return {11'h000, data_setting_error, fault_exp() != 16'h0,
        drive_ready, reverse_state, run_state};
      16'h2521: return fault_exp();
      16'h2522: return {8'h00, relay_output, 2'h0, terminal_input};
      16'h252F: return ID_VALUE;
      16'h2528, 16'h252E, 16'h2530: return 16'h0000;
      default: return meas[a < 16'h2528 ? a - 16'h2523 :
        a < 16'h252E ? a - 16'h2524 : a - 16'h2527];
    endcase
  endfunction : reg_exp

  function automatic logic [7:0] hx(input logic [3:0] v);
    return v < 4'hA ? 8'h30 + v : 8'h37 + v;
  endfunction : hx

  // Frame check: CRC low first, or text with LRC and line end
  task automatic wrap(input bit asc, inout logic [7:0] q[$]);
    logic [15:0] c;
    logic [7:0] s;
    logic [7:0] a[$];
    c = 16'hFFFF;
    s = 8'h00;
    foreach (q[i])
    begin
      s += q[i];
      c ^= {8'h00, q[i]};
      repeat (8) c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
      a.push_back(hx(q[i][7:4]));
      a.push_back(hx(q[i][3:0]));
    end
    s = 8'h00 - s;
    if (asc)
      q = {8'h3A, a, hx(s[7:4]), hx(s[3:0]), 8'h0D, 8'h0A};
    else
      q = {q, c[7:0], c[15:8]};
  endtask : wrap

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic print_verdict();
    $display("Compares %0d, errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : print_verdict

  // One request; exc 00 normal, FF no reply, else exception code
  task automatic req(input logic [7:0] sa, input logic [7:0] fn,
    input logic [15:0] start, input logic [15:0] qty,
    input logic [7:0] exc, input bit slow);
    logic [7:0] r[$];
    logic [7:0] e[$];
    logic [15:0] v;
    u_master.send('{sa, fn, start[15:8], start[7:0], qty[15:8], qty[7:0]});
    if (u_master.hung)
      num_errors++;
    if (exc == 8'h00)
      e = {sa, fn, 8'(qty << 1)};
    else if (exc != 8'hFF)
      e = {sa, fn | EXC_FLAG, exc};
    for (int i = 0; exc == 8'h00 && i < qty; i++)
    begin
      v = reg_exp(start + 16'(i));
      e.push_back(v[15:8]);
      e.push_back(v[7:0]);
    end
    if (e.size() > 0)
      wrap(ascii_mode, e);
    u_master.collect(r, slow);
    chk(16'(r.size()), 16'(e.size()));
    foreach (e[i]) chk({8'h00, r[i]}, {8'h00, e[i]});
  endtask : req

  // ==========================================================
  // Main sequence
  initial
  begin
    foreach (meas[i]) meas[i] = 16'h8001 + 16'(i) * 16'h0F0F;
    repeat (2) @(posedge sys_clk);
    #1 reset = 1'h0;
    @(posedge sys_clk);
    #1;
    req(station_addr, FUNC_READ, 16'h2520, 16'h0013, 8'h00, 1'h1);
    for (int c = 0; c <= 8'h32; c++)
    begin
      drive_fault_code = 8'(c);
      ascii_mode = c[0];
      repeat (2) @(posedge sys_clk);
      #1;
      chk({8'h00, display_fault_code}, fault_exp());
      req(station_addr, FUNC_READ, 16'h2520, 16'h0002, 8'h00, 1'h0);
    end
    drive_fault_code = 8'hFF;
    for (int k = 0; k < 3; k++)
    begin
      link_failure_fault = (k > 0);
      external_abnormal_cmd = (k == 1);
      repeat (2) @(posedge sys_clk);
      #1;
      chk({8'h00, display_fault_code}, fault_exp());
      req(station_addr, FUNC_READ, 16'h2521, 16'h0001, 8'h00, 1'h1);
    end
    ascii_mode = 1'h0;
    req(station_addr, 8'h04, 16'h2520, 16'h0001, EXC_BAD_FUNC, 1'h0);
    req(station_addr, FUNC_READ, 16'h2533, 16'h0001, EXC_BAD_ADDR, 1'h0);
    req(station_addr, FUNC_READ, 16'h2532, 16'h0000, EXC_BAD_AMOUNT, 1'h0);
    req(station_addr, FUNC_READ, 16'h2520, 16'h0026, EXC_BAD_AMOUNT, 1'h0);
    req(station_addr, FUNC_READ, 16'h2520, 16'h0025, EXC_BAD_ADDR, 1'h0);
    req(station_addr, FUNC_READ, 16'h2530, 16'h0004, EXC_BAD_ADDR, 1'h0);
    req(8'h08, FUNC_READ, 16'h2520, 16'h0001, 8'hFF, 1'h0);
    req(BROADCAST_ADDR, FUNC_READ, 16'h2520, 16'h0001, 8'hFF, 1'h0);
    req(station_addr, FUNC_WRITE_ONE, 16'h2520, 16'h0001, 8'hFF, 1'h0);
    ascii_mode = 1'h1;
    req(station_addr, FUNC_READ, 16'h2520, 16'h0012, EXC_BAD_AMOUNT, 1'h1);
    req(station_addr, FUNC_READ, 16'h2521, 16'h0011, 8'h00, 1'h1);
    print_verdict();
  end
endmodule : drive_monitor_register_read_tb_top
